// ---- include/remote_contact_consts.svh ----
// Summary of operation
// - Legacy profile: alarm or warning opens break pair, closes make pair.
// - Standard profile alarm: break closed on power off or alarm, else open.
// - Standard profile warning: break closed on power off or warning, else open.
// - Legacy profile drops remote-available during power-failure regenerative braking.
// - Standard profile keeps remote-available on whenever remote operation is permitted.
// - Remote-only qualifier: opened stop acts only in remote mode.
// - Remote-and-serial qualifier: opened stop also acts under either serial link.
// - Momentary wiring: start closure starts pump, stop opening stops it.
// - Alternate wiring: pump runs while stop closed, stops when opened.
// - Defaults: legacy alarm and remote profiles, remote-only stop qualifier.
// - Defaults: first serial link 9600 bit/s, event sending on.
// - Defaults: shared bus addressing off, station identifier 01, events on.
// - Defaults: speed in percent, normal run speed, reduced setpoint 100.0 percent.
// - Stop request wins over a simultaneous start request.
// - One reset request per closure of the reset contact.
// - Remote outputs stay inactive about 6 seconds after power-on.
`ifndef REMOTE_CONTACT_CONSTS_SVH
`define REMOTE_CONTACT_CONSTS_SVH

// ----------------------------------------
// Timing
// ----------------------------------------
`define CLK_HZ               100000000
`define CLK_MHZ              100
`define POWERUP_HOLD_S       6
`define POWERUP_HOLD_CYCLES  (`POWERUP_HOLD_S * `CLK_HZ)
`define DEBOUNCE_US          1000
`define DEBOUNCE_CYCLES      (`DEBOUNCE_US * `CLK_MHZ)

// ----------------------------------------
// Register offsets
// ----------------------------------------
`define ADDR_CTRL            8'h00
`define ADDR_SER1            8'h04
`define ADDR_SER2            8'h08
`define ADDR_SPEED           8'h0c
`define ADDR_STATUS          8'h10
`define ADDR_IRQ_STAT        8'h14
`define ADDR_IRQ_MASK        8'h18

// ----------------------------------------
// Fields and reset values
// ----------------------------------------
`define CTRL_ALARM_STD_BIT   0
`define CTRL_REMOTE_STD_BIT  1
`define CTRL_STOP_SERIAL_BIT 2
`define CTRL_ALT_WIRING_BIT  3
`define CTRL_RESTORE_BIT     31
`define CTRL_W               4
`define CTRL_RST             4'h0
`define SER1_RST             32'h0001_2580
`define SER2_RST             32'h0102_2580
`define SPEED_RST            32'h03e8_0000
`define IRQ_W                4
`define IRQ_START_BIT        0
`define IRQ_STOP_BIT         1
`define IRQ_RESET_BIT        2
`define IRQ_ENABLED_BIT      3

`endif

// ---- include/remote_contact_pkg.sv ----
package remote_contact_pkg;

    typedef enum logic [3:0] {
        OP_LOCAL  = 4'b0001,
        OP_REMOTE = 4'b0010,
        OP_SER1   = 4'b0100,
        OP_SER2   = 4'b1000
    } op_mode_e;

    typedef enum logic [1:0] {
        PU_HOLD = 2'b01,
        PU_RUN  = 2'b10
    } pu_state_e;

    // Pin level high means contact open
    typedef struct packed {
        logic low_speed;
        logic reset;
        logic stop;
        logic start;
    } contact_in_s;

    // Coil high: make pair closed, break pair open
    typedef struct packed {
        logic remote;
        logic warning;
        logic alarm;
    } relay_out_s;

    typedef struct packed {
        logic start;
        logic stop;
        logic reset;
        logic low_speed;
    } pump_cmd_s;

endpackage

// ---- rtl/contact_input_filter.sv ----
`timescale 1ns/1ps
`include "remote_contact_consts.svh"

module contact_input_filter #(
    parameter int unsigned SETTLE_CYCLES = `DEBOUNCE_CYCLES
) (
    input  wire logic sys_clk_i,
    input  wire logic reset_i,
    input  wire logic pin_i,
    output logic      closed_o
);

    logic [2:0]  sync_ff;
    logic [19:0] cnt_ff;
    logic        level_ff;
    logic [19:0] nxt_cnt;

    // Only the second and third stage are compared
    wire         agree   = (sync_ff[1] == sync_ff[2]);
    wire         differs = agree && (sync_ff[2] != level_ff);
    wire         settled = (cnt_ff >= 20'(SETTLE_CYCLES - 1));

    assign nxt_cnt  = differs ? (settled ? 20'h0 : cnt_ff + 20'h1) : 20'h0;
    assign closed_o = ~level_ff;

    always_ff @(posedge sys_clk_i) begin
        if (reset_i) begin
            sync_ff  <= 3'h7;
            cnt_ff   <= 20'h0;
            level_ff <= 1'b1;
        end else begin
            sync_ff  <= {sync_ff[1:0], pin_i};
            cnt_ff   <= nxt_cnt;
            if (differs && settled) begin
                level_ff <= sync_ff[2];
            end
        end
    end

endmodule

// ---- rtl/remote_contact_io_logic.sv ----
`timescale 1ns/1ps
`include "remote_contact_consts.svh"

module remote_contact_io_logic
    import remote_contact_pkg::*;
#(
    parameter int unsigned HOLD_CYCLES     = `POWERUP_HOLD_CYCLES,
    parameter int unsigned DEBOUNCE_CYCLES = `DEBOUNCE_CYCLES
) (
    input  wire logic        sys_clk_i,
    input  wire logic        reset_i,
    input  wire contact_in_s pins_i,
    input  wire op_mode_e    op_mode_i,
    input  wire logic        alarm_i,
    input  wire logic        warning_i,
    input  wire logic        pf_brake_i,
    input  wire logic [7:0]  addr_i,
    input  wire logic [31:0] wdata_i,
    input  wire logic        wr_i,
    input  wire logic        rd_i,
    output logic [31:0]      rdata_o,
    output relay_out_s       relays_o,
    output pump_cmd_s        cmd_o,
    output logic             irq_o
);

    // ----------------------------------------
    // Contact inputs
    // ----------------------------------------
    logic [3:0]  pin_bits;
    logic [3:0]  closed_bits;
    contact_in_s closed;
    contact_in_s closed_prev_ff;

    assign pin_bits = pins_i;
    assign closed   = contact_in_s'(closed_bits);

    for (genvar i = 0; i < 4; i++) begin : g_filt
        contact_input_filter #(
            .SETTLE_CYCLES(DEBOUNCE_CYCLES)
        ) u_filt (
            .sys_clk_i(sys_clk_i),
            .reset_i  (reset_i),
            .pin_i    (pin_bits[i]),
            .closed_o (closed_bits[i])
        );
    end

    // ----------------------------------------
    // Power-up hold
    // ----------------------------------------
    pu_state_e   pu_state_ff;
    pu_state_e   nxt_pu_state;
    logic [29:0] hold_cnt_ff;
    logic [29:0] nxt_hold_cnt;

    wire hold_done = (hold_cnt_ff >= 30'(HOLD_CYCLES - 1));
    wire out_en    = (pu_state_ff == PU_RUN);

    always_comb begin
        nxt_pu_state = pu_state_ff;
        nxt_hold_cnt = hold_cnt_ff;
        unique case (pu_state_ff)
            PU_HOLD: begin
                nxt_hold_cnt = hold_cnt_ff + 30'h1;
                if (hold_done) begin
                    nxt_pu_state = PU_RUN;
                end
            end
            PU_RUN: begin
                nxt_hold_cnt = hold_cnt_ff;
            end
            default: begin
                nxt_pu_state = PU_HOLD;
            end
        endcase
    end

    always_ff @(posedge sys_clk_i) begin
        if (reset_i) begin
            pu_state_ff <= PU_HOLD;
            hold_cnt_ff <= 30'h0;
        end else begin
            pu_state_ff <= nxt_pu_state;
            hold_cnt_ff <= nxt_hold_cnt;
        end
    end

    // ----------------------------------------
    // Settings registers
    // ----------------------------------------
    logic [`CTRL_W-1:0] ctrl_ff;
    logic [31:0]        ser1_ff;
    logic [31:0]        ser2_ff;
    logic [31:0]        speed_ff;
    logic [`IRQ_W-1:0]  irq_stat_ff;
    logic [`IRQ_W-1:0]  irq_mask_ff;
    logic [31:0]        rdata_ff;

    wire wr_ctrl   = wr_i && (addr_i == `ADDR_CTRL);
    wire restore   = wr_ctrl && wdata_i[`CTRL_RESTORE_BIT];
    wire wr_ser1   = wr_i && (addr_i == `ADDR_SER1);
    wire wr_ser2   = wr_i && (addr_i == `ADDR_SER2);
    wire wr_speed  = wr_i && (addr_i == `ADDR_SPEED);
    wire wr_mask   = wr_i && (addr_i == `ADDR_IRQ_MASK);
    wire rd_irq    = rd_i && (addr_i == `ADDR_IRQ_STAT);

    wire alarm_std  = ctrl_ff[`CTRL_ALARM_STD_BIT];
    wire remote_std = ctrl_ff[`CTRL_REMOTE_STD_BIT];
    wire stop_ser   = ctrl_ff[`CTRL_STOP_SERIAL_BIT];
    wire alt_wiring = ctrl_ff[`CTRL_ALT_WIRING_BIT];

    always_ff @(posedge sys_clk_i) begin
        if (reset_i || restore) begin
            ctrl_ff <= `CTRL_RST;
        end else if (wr_ctrl) begin
            ctrl_ff <= wdata_i[`CTRL_W-1:0];
        end
    end

    always_ff @(posedge sys_clk_i) begin
        if (reset_i || restore) begin
            ser1_ff  <= `SER1_RST;
            ser2_ff  <= `SER2_RST;
            speed_ff <= `SPEED_RST;
        end else begin
            ser1_ff  <= wr_ser1 ? wdata_i : ser1_ff;
            ser2_ff  <= wr_ser2 ? wdata_i : ser2_ff;
            speed_ff <= wr_speed ? wdata_i : speed_ff;
        end
    end

    // ----------------------------------------
    // Remote command decode
    // ----------------------------------------
    wire remote_mode = (op_mode_i == OP_REMOTE);
    wire serial_mode = (op_mode_i == OP_SER1) || (op_mode_i == OP_SER2);
    wire stop_open   = ~closed.stop;

    wire stop_scope  = remote_mode || (stop_ser && serial_mode);

    wire start_edge  = closed.start && !closed_prev_ff.start;
    wire stop_edge   = closed.stop && !closed_prev_ff.stop;
    wire reset_edge  = closed.reset && !closed_prev_ff.reset;

    wire start_src   = alt_wiring ? stop_edge : start_edge;

    wire start_req   = out_en && remote_mode && start_src && !stop_open;
    wire stop_req    = out_en && stop_scope && stop_open;

    wire reset_req   = out_en && remote_mode && reset_edge;
    wire low_req     = out_en && remote_mode && closed.low_speed;

    // ----------------------------------------
    // Contact outputs
    // ----------------------------------------
    // alarm profile
    wire alarm_coil   = out_en && (alarm_std ? !alarm_i : alarm_i);

    wire warning_coil = out_en && (alarm_std ? !warning_i : warning_i);

    wire remote_coil  = out_en && remote_mode && (remote_std || !pf_brake_i);

    always_ff @(posedge sys_clk_i) begin
        if (reset_i) begin
            relays_o       <= '0;
            cmd_o          <= '0;
            closed_prev_ff <= '0;
        end else begin
            relays_o       <= '{remote: remote_coil, warning: warning_coil, alarm: alarm_coil};
            cmd_o          <= '{start: start_req, stop: stop_req, reset: reset_req, low_speed: low_req};
            closed_prev_ff <= closed;
        end
    end

    // ----------------------------------------
    // Events and interrupt
    // ----------------------------------------
    logic [`IRQ_W-1:0] events;
    logic [`IRQ_W-1:0] nxt_irq_stat;
    logic              out_en_prev_ff;

    // Stop event only on its first cycle, not while it stands
    assign events = {out_en && !out_en_prev_ff, reset_req, stop_req && !cmd_o.stop, start_req};

    // Set wins over read clear
    assign nxt_irq_stat = (irq_stat_ff & ~(rd_irq ? {`IRQ_W{1'b1}} : {`IRQ_W{1'b0}})) | events;

    always_ff @(posedge sys_clk_i) begin
        if (reset_i) begin
            irq_stat_ff    <= '0;
            irq_mask_ff    <= '0;
            out_en_prev_ff <= 1'b0;
        end else begin
            irq_stat_ff    <= nxt_irq_stat;
            irq_mask_ff    <= wr_mask ? wdata_i[`IRQ_W-1:0] : irq_mask_ff;
            out_en_prev_ff <= out_en;
        end
    end

    assign irq_o = |(irq_stat_ff & irq_mask_ff);

    // ----------------------------------------
    // Read path
    // ----------------------------------------
    logic [31:0] rd_mux;
    wire  [31:0] status_word = {20'h0, op_mode_i, closed_bits, out_en, relays_o};

    always_comb begin
        unique case (addr_i)
            `ADDR_CTRL:     rd_mux = {28'h0, ctrl_ff};
            `ADDR_SER1:     rd_mux = ser1_ff;
            `ADDR_SER2:     rd_mux = ser2_ff;
            `ADDR_SPEED:    rd_mux = speed_ff;
            `ADDR_STATUS:   rd_mux = status_word;
            `ADDR_IRQ_STAT: rd_mux = {28'h0, irq_stat_ff};
            `ADDR_IRQ_MASK: rd_mux = {28'h0, irq_mask_ff};
            default:        rd_mux = 32'h0;
        endcase
    end

    // Read data valid only in the cycle after the strobe
    always_ff @(posedge sys_clk_i) begin
        if (reset_i) begin
            rdata_ff <= 32'h0;
        end else begin
            rdata_ff <= rd_i ? rd_mux : 32'h0;
        end
    end

    assign rdata_o = rdata_ff;

    // ----------------------------------------
    // Checks
    // ----------------------------------------
    chk_alarm_legacy_out: assert property (@(posedge sys_clk_i) disable iff (reset_i)
        out_en && !alarm_std |=> relays_o.alarm == $past(alarm_i))
        else $error("legacy alarm contact wrong");

    chk_alarm_std_out: assert property (@(posedge sys_clk_i) disable iff (reset_i)
        out_en && alarm_std |=> relays_o.alarm == !$past(alarm_i))
        else $error("standard alarm contact wrong");

    chk_warning_std_out: assert property (@(posedge sys_clk_i) disable iff (reset_i)
        out_en && alarm_std && warning_i |=> !relays_o.warning)
        else $error("standard warning contact wrong");

    chk_remote_pf_drop: assert property (@(posedge sys_clk_i) disable iff (reset_i)
        !remote_std && pf_brake_i |=> !relays_o.remote)
        else $error("remote held during braking");

    chk_remote_std_hold: assert property (@(posedge sys_clk_i) disable iff (reset_i)
        out_en && remote_std && remote_mode |=> relays_o.remote)
        else $error("standard remote dropped");

    chk_stop_local_ign: assert property (@(posedge sys_clk_i) disable iff (reset_i)
        op_mode_i == OP_LOCAL || (serial_mode && !stop_ser) |=> !cmd_o.stop)
        else $error("stop acted outside scope");

    chk_stop_serial_act: assert property (@(posedge sys_clk_i) disable iff (reset_i)
        out_en && stop_ser && serial_mode && stop_open |=> cmd_o.stop)
        else $error("serial stop interlock missed");

    chk_start_momentary: assert property (@(posedge sys_clk_i) disable iff (reset_i)
        out_en && !alt_wiring && remote_mode && start_edge && !stop_open |=> cmd_o.start)
        else $error("momentary start missed");

    chk_start_alternate: assert property (@(posedge sys_clk_i) disable iff (reset_i)
        out_en && alt_wiring && remote_mode && stop_edge |=> cmd_o.start)
        else $error("alternate start missed");

    chk_stop_priority: assert property (@(posedge sys_clk_i) disable iff (reset_i)
        cmd_o.stop && $past(remote_mode) |-> !cmd_o.start)
        else $error("start issued during stop");

    chk_reset_single: assert property (@(posedge sys_clk_i) disable iff (reset_i)
        cmd_o.reset |=> !cmd_o.reset)
        else $error("reset request repeated");

    chk_hold_inactive: assert property (@(posedge sys_clk_i) disable iff (reset_i)
        !out_en |=> relays_o == '0 && cmd_o == '0)
        else $error("output active during hold");

    chk_defaults_load: assert property (@(posedge sys_clk_i)
        reset_i |=> ctrl_ff == `CTRL_RST && ser1_ff == `SER1_RST && ser2_ff == `SER2_RST && speed_ff == `SPEED_RST)
        else $error("defaults not loaded");

    chk_irq_set_wins: assert property (@(posedge sys_clk_i) disable iff (reset_i)
        (|events) |=> (irq_stat_ff & $past(events)) == $past(events))
        else $error("event lost in status");

    chk_rdata_idle: assert property (@(posedge sys_clk_i) disable iff (reset_i)
        !rd_i |=> rdata_o == 32'h0)
        else $error("read data outside read cycle");

endmodule

// ---- tb/switch_panel.sv ----
`timescale 1ns/1ps

// ----------------------------------------
// External contact panel
// ----------------------------------------
module switch_panel
    import remote_contact_pkg::*;
(
    input  wire logic       sys_clk_i,
    input  wire logic [3:0] close_i,
    output contact_in_s     pins_o
);
    // Contacts switch only after an edge; a closed contact pulls the pin to ground
    always_ff @(posedge sys_clk_i) begin
        pins_o <= ~close_i;
    end
endmodule

// ---- tb/remote_contact_io_logic_tb.sv ----
`timescale 1ns/1ps

module remote_contact_io_logic_tb
    import remote_contact_pkg::*;
;
    // ----------------------------------------
    // Signals
    // ----------------------------------------
    logic        sys_clk_i = 1'b0;
    logic        reset_i   = 1'b1;
    logic [3:0]  close     = 4'h2;
    contact_in_s pins;
    op_mode_e    op_mode   = OP_LOCAL;
    logic        alarm_i   = 1'b0;
    logic        warning_i = 1'b0;
    logic        pf_brake_i = 1'b0;
    logic [7:0]  addr_i    = 8'h00;
    logic [31:0] wdata_i   = 32'h0;
    logic        wr_i      = 1'b0;
    logic        rd_i      = 1'b0;
    logic [31:0] rdata_o;
    relay_out_s  relays_o;
    pump_cmd_s   cmd_o;
    logic        irq_o;
    int          n_fail    = 0;
    int          comparisons = 0;
    int          cyc       = 0;
    logic [31:0] d;
    int          c;

    always #5 sys_clk_i = ~sys_clk_i;

    switch_panel panel (.sys_clk_i(sys_clk_i), .close_i(close), .pins_o(pins));

    // Short counts keep the power-up hold and debounce quick in simulation
    remote_contact_io_logic #(.HOLD_CYCLES(50), .DEBOUNCE_CYCLES(4)) dut (
        .sys_clk_i(sys_clk_i), .reset_i(reset_i), .pins_i(pins), .op_mode_i(op_mode),
        .alarm_i(alarm_i), .warning_i(warning_i), .pf_brake_i(pf_brake_i), .addr_i(addr_i),
        .wdata_i(wdata_i), .wr_i(wr_i), .rd_i(rd_i), .rdata_o(rdata_o), .relays_o(relays_o),
        .cmd_o(cmd_o), .irq_o(irq_o));

    // ----------------------------------------
    // Helpers
    // ----------------------------------------
    task automatic end_of_test();
        $display("checks %0d failures %0d", comparisons, n_fail);
        if (n_fail == 0 && comparisons > 0) begin
            $display("*** PASS ***");
        end else begin
            $display("*** FAIL ***");
        end
        $finish;
    endtask

    task automatic chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
        comparisons++;
        if (got !== exp) begin
            n_fail++;
            $display("[ERR] %s expected %h seen %h", nm, exp, got);
        end
    endtask

    task automatic tick(input int n);
        repeat (n) @(posedge sys_clk_i);
        #1;
    endtask

    task automatic wr(input logic [7:0] a, input logic [31:0] v);
        @(posedge sys_clk_i);
        wr_i <= 1'b1;
        addr_i <= a;
        wdata_i <= v;
        @(posedge sys_clk_i);
        wr_i <= 1'b0;
    endtask

    task automatic rd(input logic [7:0] a, output logic [31:0] v);
        @(posedge sys_clk_i);
        rd_i <= 1'b1;
        addr_i <= a;
        @(posedge sys_clk_i);
        rd_i <= 1'b0;
        #1 v = rdata_o;
    endtask

    task automatic pins_to(input logic [3:0] v);
        @(posedge sys_clk_i);
        close <= v;
    endtask

    // Counts cycles in which one command bit is high
    task automatic cnt(input int n, input int idx, output int k);
        logic [3:0] cv;
        k = 0;
        repeat (n) begin
            @(posedge sys_clk_i);
            #1 cv = cmd_o;
            if (cv[idx] === 1'b1) k++;
        end
    endtask

    // ----------------------------------------
    // Scenarios
    // ----------------------------------------
    task automatic t_defaults();
        alarm_i <= 1'b1;
        rd(8'h00, d); chk("ctrl", 32'h0, d);
        rd(8'h04, d); chk("ser1", 32'h0001_2580, d);
        rd(8'h08, d); chk("ser2", 32'h0102_2580, d);
        rd(8'h0c, d); chk("speed", 32'h03e8_0000, d);
        rd(8'h1c, d); chk("unmapped", 32'h0, d);
        tick(20);
        chk("relay hold", 32'h0, relays_o);
        tick(40);
        chk("relay enabled", 32'h1, relays_o[0]);
        rd(8'h14, d); chk("irq enabled", 32'h8, d & 32'h8);
    endtask

    task automatic t_relays();
        logic e;
        for (int s = 0; s < 2; s++) begin
            wr(8'h00, s);
            for (int a = 0; a < 2; a++) begin
                @(posedge sys_clk_i);
                alarm_i <= a[0];
                warning_i <= a[0];
                tick(3);
                e = s[0] ? ~a[0] : a[0];
                chk("alarm warning", {e, e}, relays_o[1:0]);
            end
        end
        @(posedge sys_clk_i);
        alarm_i <= 1'b0;
        warning_i <= 1'b0;
    endtask

    task automatic t_remote();
        op_mode <= OP_REMOTE;
        pf_brake_i <= 1'b1;
        wr(8'h00, 32'h0); tick(3); chk("remote legacy brake", 32'h0, relays_o[2]);
        wr(8'h00, 32'h2); tick(3); chk("remote std brake", 32'h1, relays_o[2]);
        @(posedge sys_clk_i);
        pf_brake_i <= 1'b0;
        wr(8'h00, 32'h0); tick(3); chk("remote legacy", 32'h1, relays_o[2]);
        rd(8'h10, d); chk("status", 32'h0000_022c, d);
    endtask

    task automatic t_momentary();
        wr(8'h18, 32'h1);
        rd(8'h18, d); chk("mask", 32'h1, d);
        rd(8'h14, d);
        pins_to(4'h3); cnt(30, 3, c); chk("start pulses", 32'h1, c);
        chk("irq start", 32'h1, irq_o);
        rd(8'h14, d); chk("stat start", 32'h1, d & 32'h1);
        tick(1); chk("irq cleared", 32'h0, irq_o);
        pins_to(4'h2); tick(20);
        pins_to(4'h0); tick(20); chk("stop open", 32'h1, cmd_o.stop);
        pins_to(4'h1); cnt(30, 3, c); chk("start under stop", 32'h0, c);
        pins_to(4'h2); tick(20); chk("stop closed", 32'h0, cmd_o.stop);
        wr(8'h18, 32'h0);
    endtask

    task automatic t_qualifier();
        op_mode <= OP_SER1;
        pins_to(4'h0); tick(20); chk("stop serial ignored", 32'h0, cmd_o.stop);
        wr(8'h00, 32'h4); tick(3); chk("stop serial1", 32'h1, cmd_o.stop);
        @(posedge sys_clk_i);
        op_mode <= OP_SER2;
        tick(3); chk("stop serial2", 32'h1, cmd_o.stop);
        wr(8'h00, 32'h0);
        pins_to(4'h2);
        op_mode <= OP_REMOTE;
        tick(20);
    endtask

    task automatic t_reset_contact();
        rd(8'h14, d);
        pins_to(4'h6); cnt(40, 1, c); chk("reset first", 32'h1, c);
        cnt(20, 1, c); chk("reset held", 32'h0, c);
        pins_to(4'h2); tick(20);
        pins_to(4'h6); cnt(30, 1, c); chk("reset again", 32'h1, c);
        pins_to(4'h2); tick(20);
        rd(8'h14, d); chk("stat reset", 32'h4, d & 32'h4);
        pins_to(4'ha); tick(20); chk("low speed", 32'h1, cmd_o.low_speed);
        pins_to(4'h2); tick(20); chk("low speed off", 32'h0, cmd_o.low_speed);
    endtask

    task automatic t_alternate();
        wr(8'h00, 32'h8);
        rd(8'h14, d);
        pins_to(4'h0); tick(20); chk("alt stop", 32'h1, cmd_o.stop);
        rd(8'h14, d); chk("stat stop", 32'h2, d & 32'h2);
        pins_to(4'h2); cnt(30, 3, c); chk("alt run", 32'h1, c);
        chk("alt stop released", 32'h0, cmd_o.stop);
    endtask

    task automatic t_restore();
        wr(8'h04, 32'h0);
        wr(8'h00, 32'h8000_0000);
        rd(8'h00, d); chk("ctrl restored", 32'h0, d);
        rd(8'h04, d); chk("ser1 restored", 32'h0001_2580, d);
    endtask

    // ----------------------------------------
    // Run
    // ----------------------------------------
    always @(posedge sys_clk_i) begin
        cyc++;
        if (cyc == 20000) begin
            n_fail++;
            end_of_test();
        end
    end

    initial begin
        repeat (6) @(posedge sys_clk_i);
        reset_i <= 1'b0;
        t_defaults();
        t_relays();
        t_remote();
        t_momentary();
        t_qualifier();
        t_reset_contact();
        t_alternate();
        t_restore();
        end_of_test();
    end
endmodule
